//--- cmdsel_core.v
// Contract
// - Serial-link source code and field-bus source code are kept as separate settings.
// - Serial code 0..8 picks frequency and run source each from local, keypad link, terminal link.
// - Field-bus code 0..3: none, frequency, run, or both taken from the field bus.
// - Local frequency from setting or multistep; local run from keypad or terminals.
// - Keypad-port link shares the keypad connector; terminal link uses terminal-block port.
// - Assigned link-enable input active: both source codes apply as configured.
// - Assigned link-enable input inactive: both commands come from local sources.
// - Remote party reads operating data and settings, writes frequency and run commands.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`include "cmdsel_consts.vh"

module cmdsel_core #(
	parameter FREQ_W = 16,
	parameter RUN_W  = 2
) (
	input  wire              clk,
	input  wire              reset_n,
	input  wire [3:0]        avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [31:0]       avs_writedata,
	input  wire [3:0]        avs_byteenable,
	output reg  [31:0]       avs_readdata,
	output wire              avs_waitrequest,
	input  wire              link_enable_input,
	input  wire              multistep_select,
	input  wire [RUN_W-1:0]  terminal_run,
	input  wire [FREQ_W-1:0] primary_freq,
	input  wire [FREQ_W-1:0] secondary_freq,
	input  wire [FREQ_W-1:0] multistep_freq,
	input  wire [RUN_W-1:0]  keypad_run,
	input  wire [FREQ_W-1:0] keypad_link_freq,
	input  wire [RUN_W-1:0]  keypad_link_run,
	input  wire [FREQ_W-1:0] term_link_freq,
	input  wire [RUN_W-1:0]  term_link_run,
	input  wire [FREQ_W-1:0] fieldbus_freq,
	input  wire [RUN_W-1:0]  fieldbus_run,
	output reg  [FREQ_W-1:0] freq_cmd,
	output reg  [RUN_W-1:0]  run_cmd,
	output reg  [1:0]        freq_source,
	output reg  [1:0]        run_source
);

	// One synchroniser lane per pin: link-enable, multistep select, terminal run
	localparam SYNC_W = RUN_W + 2;

	// Frequency source picked by a serial-link code
	function [1:0] ser_freq_src;
		input [3:0] code;
		begin
			case (code)
				4'h0: ser_freq_src = `CMDSEL_SRC_LOCAL;
				4'h1: ser_freq_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h2: ser_freq_src = `CMDSEL_SRC_LOCAL;
				4'h3: ser_freq_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h4: ser_freq_src = `CMDSEL_SRC_TERM_LINK;
				4'h5: ser_freq_src = `CMDSEL_SRC_TERM_LINK;
				4'h6: ser_freq_src = `CMDSEL_SRC_LOCAL;
				4'h7: ser_freq_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h8: ser_freq_src = `CMDSEL_SRC_TERM_LINK;
				default: ser_freq_src = `CMDSEL_SRC_LOCAL;
			endcase
		end
	endfunction

	// Run source picked by a serial-link code
	function [1:0] ser_run_src;
		input [3:0] code;
		begin
			case (code)
				4'h0: ser_run_src = `CMDSEL_SRC_LOCAL;
				4'h1: ser_run_src = `CMDSEL_SRC_LOCAL;
				4'h2: ser_run_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h3: ser_run_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h4: ser_run_src = `CMDSEL_SRC_LOCAL;
				4'h5: ser_run_src = `CMDSEL_SRC_KEYPAD_LINK;
				4'h6: ser_run_src = `CMDSEL_SRC_TERM_LINK;
				4'h7: ser_run_src = `CMDSEL_SRC_TERM_LINK;
				4'h8: ser_run_src = `CMDSEL_SRC_TERM_LINK;
				default: ser_run_src = `CMDSEL_SRC_LOCAL;
			endcase
		end
	endfunction

	// Pin synchronisers
	// Only the second stage feeds logic; the first may still be settling
	wire [SYNC_W-1:0] pin_async;
	reg  [SYNC_W-1:0] pin_meta;
	reg  [SYNC_W-1:0] pin_sync;

	assign pin_async = {terminal_run, multistep_select, link_enable_input};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_async[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	wire             link_level;
	wire             ms_level;
	wire [RUN_W-1:0] term_run_level;

	assign link_level     = pin_sync[0];
	assign ms_level       = pin_sync[1];
	assign term_run_level = pin_sync[SYNC_W-1:2];

	// Software settings
	reg [3:0] serial_link_source_code;
	reg [1:0] fieldbus_source_code;
	reg       link_enable_assigned;
	reg       local_freq_select;
	reg       local_run_source_setting;

	// Bus handshake: every access is answered on the second edge
	reg  bus_ack;
	wire bus_req;
	wire bus_take;

	assign bus_req         = avs_read | avs_write;
	assign bus_take        = bus_req & ~bus_ack;
	assign avs_waitrequest = bus_req & ~bus_ack;

	// Ack lasts one cycle, so a request still held begins a fresh access
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_take;
		end
	end

	// Register writes take effect on the edge the master sees waitrequest low
	wire wr_now;
	wire wr_ctrl;
	wire wr_local;

	assign wr_now   = avs_write & bus_ack;
	assign wr_ctrl  = wr_now & (avs_address == `CMDSEL_OFS_CTRL);
	assign wr_local = wr_now & (avs_address == `CMDSEL_OFS_LOCAL);

	// Only the serial code has a range to police; the field-bus code uses all four values
	wire [3:0] wr_ser_code;
	assign wr_ser_code = avs_writedata[`CMDSEL_CTRL_SER_MSB:`CMDSEL_CTRL_SER_LSB];

	// Two independent codes; an out-of-range serial code keeps the old value
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_link_source_code <= `CMDSEL_RST_SER_CODE;
			fieldbus_source_code    <= `CMDSEL_RST_FB_CODE;
			link_enable_assigned    <= `CMDSEL_RST_LINK_ASSIGN;
		end else if (wr_ctrl) begin
			if (avs_byteenable[0] && wr_ser_code <= `CMDSEL_SER_CODE_MAX) begin
				serial_link_source_code <= wr_ser_code;
			end
			if (avs_byteenable[0]) begin
				fieldbus_source_code <= avs_writedata[`CMDSEL_CTRL_FB_MSB:`CMDSEL_CTRL_FB_LSB];
			end
			if (avs_byteenable[1]) begin
				link_enable_assigned <= avs_writedata[`CMDSEL_CTRL_LINK_ASSIGN];
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			local_freq_select        <= `CMDSEL_RST_FREQ_SEL;
			local_run_source_setting <= `CMDSEL_RST_RUN_SEL;
		end else if (wr_local && avs_byteenable[0]) begin
			local_freq_select        <= avs_writedata[`CMDSEL_LOCAL_FREQ_SEL];
			local_run_source_setting <= avs_writedata[`CMDSEL_LOCAL_RUN_SEL];
		end
	end

	// Codes apply when link-enable is unassigned or its input is on
	wire codes_effective;
	assign codes_effective = ~link_enable_assigned | link_level;

	// Source choice
	// Field-bus code overrides per command; link-enable off forces both local
	reg [1:0] next_freq_source;
	reg [1:0] next_run_source;

	always @* begin
		next_freq_source = ser_freq_src(serial_link_source_code);
		next_run_source  = ser_run_src(serial_link_source_code);
		if (fieldbus_source_code == `CMDSEL_FB_FREQ || fieldbus_source_code == `CMDSEL_FB_BOTH) begin
			next_freq_source = `CMDSEL_SRC_FIELDBUS;
		end
		if (fieldbus_source_code == `CMDSEL_FB_RUN || fieldbus_source_code == `CMDSEL_FB_BOTH) begin
			next_run_source = `CMDSEL_SRC_FIELDBUS;
		end
		if (!codes_effective) begin
			next_freq_source = `CMDSEL_SRC_LOCAL;
			next_run_source  = `CMDSEL_SRC_LOCAL;
		end
	end

	// Local commands
	// The multistep pin overrides the software frequency choice
	reg [FREQ_W-1:0] local_freq;
	reg [RUN_W-1:0]  local_run;

	always @* begin
		if (ms_level) begin
			local_freq = multistep_freq;
		end else if (local_freq_select) begin
			local_freq = secondary_freq;
		end else begin
			local_freq = primary_freq;
		end
		if (local_run_source_setting) begin
			local_run = term_run_level;
		end else begin
			local_run = keypad_run;
		end
	end

	// Command multiplexers
	reg [FREQ_W-1:0] next_freq_cmd;
	reg [RUN_W-1:0]  next_run_cmd;

	always @* begin
		case (next_freq_source)
			`CMDSEL_SRC_LOCAL:       next_freq_cmd = local_freq;
			`CMDSEL_SRC_KEYPAD_LINK: next_freq_cmd = keypad_link_freq;
			`CMDSEL_SRC_TERM_LINK:   next_freq_cmd = term_link_freq;
			`CMDSEL_SRC_FIELDBUS:    next_freq_cmd = fieldbus_freq;
			default:                 next_freq_cmd = local_freq;
		endcase
		case (next_run_source)
			`CMDSEL_SRC_LOCAL:       next_run_cmd = local_run;
			`CMDSEL_SRC_KEYPAD_LINK: next_run_cmd = keypad_link_run;
			`CMDSEL_SRC_TERM_LINK:   next_run_cmd = term_link_run;
			`CMDSEL_SRC_FIELDBUS:    next_run_cmd = fieldbus_run;
			default:                 next_run_cmd = local_run;
		endcase
	end

	// Commands and their source codes change on the same edge
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			freq_cmd    <= {FREQ_W{1'b0}};
			run_cmd     <= {RUN_W{1'b0}};
			freq_source <= `CMDSEL_SRC_LOCAL;
			run_source  <= `CMDSEL_SRC_LOCAL;
		end else begin
			freq_cmd    <= next_freq_cmd;
			run_cmd     <= next_run_cmd;
			freq_source <= next_freq_source;
			run_source  <= next_run_source;
		end
	end

	// Read data, captured on the edge that takes the request
	reg [31:0] next_readdata;

	always @* begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`CMDSEL_OFS_CTRL: begin
				next_readdata[`CMDSEL_CTRL_SER_MSB:`CMDSEL_CTRL_SER_LSB] = serial_link_source_code;
				next_readdata[`CMDSEL_CTRL_FB_MSB:`CMDSEL_CTRL_FB_LSB]   = fieldbus_source_code;
				next_readdata[`CMDSEL_CTRL_LINK_ASSIGN]                  = link_enable_assigned;
			end
			`CMDSEL_OFS_LOCAL: begin
				next_readdata[`CMDSEL_LOCAL_FREQ_SEL] = local_freq_select;
				next_readdata[`CMDSEL_LOCAL_RUN_SEL]  = local_run_source_setting;
			end
			`CMDSEL_OFS_STATUS: begin
				next_readdata[`CMDSEL_STAT_FSRC_LSB+1:`CMDSEL_STAT_FSRC_LSB] = freq_source;
				next_readdata[`CMDSEL_STAT_RSRC_LSB+1:`CMDSEL_STAT_RSRC_LSB] = run_source;
				next_readdata[`CMDSEL_STAT_LINK_LEVEL]                       = link_level;
				next_readdata[`CMDSEL_STAT_EFFECTIVE]                        = codes_effective;
				next_readdata[`CMDSEL_STAT_RUN_LSB+RUN_W-1:`CMDSEL_STAT_RUN_LSB] = run_cmd;
			end
			`CMDSEL_OFS_FREQ: begin
				next_readdata[FREQ_W-1:0] = freq_cmd;
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	// Held until the next read is taken, so a slow master still sees it
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_take && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

endmodule

//--- cmdsel_consts.vh
`ifndef CMDSEL_CONSTS_VH
`define CMDSEL_CONSTS_VH

// Register byte offsets
`define CMDSEL_OFS_CTRL          4'h0
`define CMDSEL_OFS_LOCAL         4'h4
`define CMDSEL_OFS_STATUS        4'h8
`define CMDSEL_OFS_FREQ          4'hC

// Control register fields
`define CMDSEL_CTRL_SER_LSB      0
`define CMDSEL_CTRL_SER_MSB      3
`define CMDSEL_CTRL_FB_LSB       4
`define CMDSEL_CTRL_FB_MSB       5
`define CMDSEL_CTRL_LINK_ASSIGN  8

// Local register fields
`define CMDSEL_LOCAL_FREQ_SEL    0
`define CMDSEL_LOCAL_RUN_SEL     1

// Status register fields
`define CMDSEL_STAT_FSRC_LSB     0
`define CMDSEL_STAT_RSRC_LSB     2
`define CMDSEL_STAT_LINK_LEVEL   4
`define CMDSEL_STAT_EFFECTIVE    5
`define CMDSEL_STAT_RUN_LSB      6

// Reset values
`define CMDSEL_RST_SER_CODE      4'h0
`define CMDSEL_RST_FB_CODE       2'h0
`define CMDSEL_RST_LINK_ASSIGN   1'b0
`define CMDSEL_RST_FREQ_SEL      1'b0
`define CMDSEL_RST_RUN_SEL       1'b0

// Highest legal serial-link source code
`define CMDSEL_SER_CODE_MAX      4'h8

// Command source encodings
`define CMDSEL_SRC_LOCAL         2'h0
`define CMDSEL_SRC_KEYPAD_LINK   2'h1
`define CMDSEL_SRC_TERM_LINK     2'h2
`define CMDSEL_SRC_FIELDBUS      2'h3

// Field-bus source codes
`define CMDSEL_FB_NONE           2'h0
`define CMDSEL_FB_FREQ           2'h1
`define CMDSEL_FB_RUN            2'h2
`define CMDSEL_FB_BOTH           2'h3

`endif

//--- cmdsel_remote.sv
module cmdsel_remote (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        talk,
	output wire [15:0] key_freq,
	output wire [1:0]  key_run,
	output wire [15:0] term_freq,
	output wire [1:0]  term_run,
	output wire [15:0] bus_freq,
	output wire [1:0]  bus_run
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] cnt;
	// New commands every cycle while talking, frozen otherwise
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt <= 8'h00;
		else if (talk)
			cnt <= cnt + 8'h01;
	end
	assign key_freq  = {8'h1b, cnt};
	assign key_run   = cnt[1:0];
	assign term_freq = {8'h2c, cnt};
	assign term_run  = cnt[1:0] ^ 2'h2;
	assign bus_freq  = {8'h3d, ~cnt};
	assign bus_run   = ~cnt[1:0];
endmodule

//--- cmdsel_properties.sv
`include "cmdsel_consts.vh"
module cmdsel_props #(
	parameter FREQ_W = 16,
	parameter RUN_W  = 2
) (
	input wire              clk,
	input wire              reset_n,
	input wire [3:0]        avs_address,
	input wire              avs_read,
	input wire              avs_write,
	input wire [31:0]       avs_readdata,
	input wire              avs_waitrequest,
	input wire [FREQ_W-1:0] keypad_link_freq,
	input wire [FREQ_W-1:0] term_link_freq,
	input wire [FREQ_W-1:0] fieldbus_freq,
	input wire [RUN_W-1:0]  fieldbus_run,
	input wire [FREQ_W-1:0] freq_cmd,
	input wire [RUN_W-1:0]  run_cmd,
	input wire [1:0]        freq_source,
	input wire [1:0]        run_source
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_first;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	wait_one_a: assert property (s_first |=> !avs_waitrequest) else $error("wait not one cycle");
	req_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
	bad_read_a: assert property (s_first ##0 avs_read && avs_address[1:0] != 2'h0 |=>
		avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	status_view_a: assert property (s_first ##0 avs_read && avs_address == `CMDSEL_OFS_STATUS |=>
		avs_readdata[1:0] == $past(freq_source) && avs_readdata[3:2] == $past(run_source))
		else $error("status mismatch");
	key_freq_a: assert property (freq_source == `CMDSEL_SRC_KEYPAD_LINK |->
		freq_cmd == $past(keypad_link_freq)) else $error("keypad link freq");
	term_freq_a: assert property (freq_source == `CMDSEL_SRC_TERM_LINK |->
		freq_cmd == $past(term_link_freq)) else $error("terminal link freq");
	bus_freq_a: assert property (freq_source == `CMDSEL_SRC_FIELDBUS |->
		freq_cmd == $past(fieldbus_freq)) else $error("field bus freq");
	bus_run_a: assert property (run_source == `CMDSEL_SRC_FIELDBUS |->
		run_cmd == $past(fieldbus_run)) else $error("field bus run");
endmodule
bind cmdsel_core cmdsel_props #(.FREQ_W(FREQ_W), .RUN_W(RUN_W)) u_props (.clk(clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.keypad_link_freq(keypad_link_freq), .term_link_freq(term_link_freq),
	.fieldbus_freq(fieldbus_freq), .fieldbus_run(fieldbus_run), .freq_cmd(freq_cmd),
	.run_cmd(run_cmd), .freq_source(freq_source), .run_source(run_source));

//--- cmdsel_tb.sv
`include "cmdsel_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] PRI = 16'h0a01, SEC = 16'h0b02, MSF = 16'h0c03;
	reg         clk, reset_n, avs_read, avs_write, link_in, ms_sel, talk;
	reg  [3:0]  avs_address;
	reg  [31:0] avs_writedata, rd;
	reg  [1:0]  loc;
	reg  [8:0]  ctrl;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire [15:0] kf, tf, bf, freq_cmd;
	wire [1:0]  kr, tr, br, run_cmd, freq_source, run_source;
	reg  [21:0] e;
	integer     err_total, checks_done, i;
	cmdsel_core uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.link_enable_input(link_in), .multistep_select(ms_sel), .terminal_run(2'h2),
		.primary_freq(PRI), .secondary_freq(SEC), .multistep_freq(MSF), .keypad_run(2'h1),
		.keypad_link_freq(kf), .keypad_link_run(kr), .term_link_freq(tf), .term_link_run(tr),
		.fieldbus_freq(bf), .fieldbus_run(br), .freq_cmd(freq_cmd), .run_cmd(run_cmd),
		.freq_source(freq_source), .run_source(run_source));
	cmdsel_remote far (.clk(clk), .reset_n(reset_n), .talk(talk), .key_freq(kf), .key_run(kr),
		.term_freq(tf), .term_run(tr), .bus_freq(bf), .bus_run(br));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Expected {freq_source, run_source, freq_cmd, run_cmd} from the tracked settings
	function automatic [21:0] exp_out();
		reg [1:0] fs, rs;
		reg [3:0] s;
		begin
			s = ctrl[3:0];
			fs = (s == 1 || s == 3 || s == 7) ? 2'h1 : (s == 4 || s == 5 || s == 8) ? 2'h2 : 2'h0;
			rs = (s == 2 || s == 3 || s == 5) ? 2'h1 : (s >= 6) ? 2'h2 : 2'h0;
			if (ctrl[4])
				fs = 2'h3;
			if (ctrl[5])
				rs = 2'h3;
			if (ctrl[8] && !link_in) begin
				fs = 2'h0;
				rs = 2'h0;
			end
			exp_out = {fs, rs, fs == 1 ? kf : fs == 2 ? tf : fs == 3 ? bf : ms_sel ? MSF : loc[0] ? SEC : PRI,
				rs == 1 ? kr : rs == 2 ? tr : rs == 3 ? br : loc[1] ? 2'h2 : 2'h1};
		end
	endfunction
	task bus(input wr, input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			avs_read <= !wr;
			avs_write <= wr;
			avs_address <= a;
			avs_writedata <= d;
			// Wait states are sampled on rising edges; only the watchdog ends a hang
			@(posedge clk);
			while (avs_waitrequest !== 1'b0)
				@(posedge clk);
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task chk_word(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_out(input [21:0] exp);
		checks_done = checks_done + 1;
		if ({freq_source, run_source, freq_cmd, run_cmd} !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, {freq_source, run_source, freq_cmd, run_cmd}, exp);
		end
	endtask
	task set_ctrl(input [8:0] v);
		bus(1'b1, `CMDSEL_OFS_CTRL, {23'h0, v});
		ctrl = v;
		repeat (2) @(negedge clk);
	endtask
	task pin_link(input v);
		@(posedge clk);
		link_in <= v;
		repeat (4) @(negedge clk);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_total = err_total + 1;
		complete_run;
	end
	initial begin
		{reset_n, avs_read, avs_write, link_in, ms_sel, talk} = 6'h00;
		{avs_address, avs_writedata, loc, ctrl, err_total, checks_done} = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk_out(exp_out());
		bus(1'b0, `CMDSEL_OFS_CTRL, 32'h0);
		chk_word(rd, 32'h0000_0000);
		bus(1'b0, 4'h6, 32'h0);
		chk_word(rd, 32'h0000_0000);
		for (i = 0; i <= 8; i = i + 1) begin
			set_ctrl(i[8:0]);
			chk_out(exp_out());
		end
		bus(1'b1, `CMDSEL_OFS_CTRL, 32'h0000_0009);
		bus(1'b0, `CMDSEL_OFS_CTRL, 32'h0);
		chk_word(rd, {23'h0, ctrl});
		for (i = 0; i < 4; i = i + 1) begin
			set_ctrl({3'h0, i[1:0], 4'h5});
			chk_out(exp_out());
		end
		set_ctrl(9'h137);
		repeat (2) @(negedge clk);
		chk_out(exp_out());
		pin_link(1'b1);
		chk_out(exp_out());
		e = exp_out();
		bus(1'b0, `CMDSEL_OFS_STATUS, 32'h0);
		chk_word(rd, {24'h0, e[1:0], 2'h3, e[19:18], e[21:20]});
		bus(1'b0, `CMDSEL_OFS_FREQ, 32'h0);
		chk_word(rd, {16'h0, e[17:2]});
		pin_link(1'b0);
		chk_out(exp_out());
		set_ctrl(9'h000);
		bus(1'b1, `CMDSEL_OFS_LOCAL, 32'h0000_0003);
		loc = 2'h3;
		repeat (2) @(negedge clk);
		chk_out(exp_out());
		@(posedge clk);
		ms_sel <= 1'b1;
		repeat (4) @(negedge clk);
		chk_out(exp_out());
		for (i = 0; i < 3; i = i + 1) begin
			set_ctrl(i == 0 ? 9'h003 : i == 1 ? 9'h008 : 9'h030);
			@(posedge clk);
			talk <= 1'b1;
			repeat (20) @(posedge clk);
			talk <= 1'b0;
			repeat (2) @(negedge clk);
			chk_out(exp_out());
		end
		complete_run;
	end
endmodule
